// ---- hw/octal_switch_spi.sv ----
// serial command latch and fault status reporting for eight low-side switches
`timescale 1ns/1ns
`default_nettype none
`include "octal_switch_regs.svh"
module octal_switch_spi
   import octal_switch_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  reset,
   input  wire logic  cs_n,
   input  wire logic  sclk,
   input  wire logic  si,
   input  wire word_t over_temp,
   input  wire logic  over_volt,
   input  wire word_t drain_below,
   output var  logic  so,
   output var  logic  so_oe_n,
   output var  word_t switch_off
);
   typedef struct packed {
      link_state_t             link;
      logic                    cs_n_d;
      logic                    sclk_d;
      word_t                   shift;
      word_t                   command;
      word_t                   gate_off;
      logic                    ov_seen;
      logic [`FILTER_CNT_W-1:0] filter_cnt;
      logic                    so;
      logic                    so_oe_n;
      word_t                   switch_off;
   } core_state_t;

   core_state_t state_reg;
   core_state_t state_next;
   logic        cs_n_s;
   logic        sclk_s;
   logic        si_s;
   fault_flags_t flags_s;

   localparam logic [`FILTER_CNT_W-1:0] FILTER_LOAD = `FILTER_CNT_W'(`OPEN_FILTER_CYCLES);

   ////////////////////////////////////////////////////////////////////////////////
   // pin and fault flag synchronisers

   sync2 #(.W(3)) u_link_sync (
      .clk       (clk),
      .reset     (reset),
      .async_in  ({cs_n, sclk, si}),
      .reset_val (3'h4),
      .sync_out  ({cs_n_s, sclk_s, si_s})
   );

   sync2 #(.W(17)) u_fault_sync (
      .clk       (clk),
      .reset     (reset),
      .async_in  ({over_temp, over_volt, drain_below}),
      .reset_val (17'h00000),
      .sync_out  (flags_s)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // status of each output as seen at its drain

   function automatic word_t drain_status(input word_t off_now, input word_t commanded,
                                          input word_t below, input logic filter_done);
      word_t st;
      st = off_now;
      // open load pulls an off drain low; only while commanded off, after the filter
      if (filter_done) begin
         st = st & ~(commanded & below);
      end
      return st;
   endfunction : drain_status

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb begin
      logic  cs_fall;
      logic  cs_rise;
      logic  sclk_rise;
      logic  sclk_fall;
      word_t off_now;
      cs_fall   = 1'b0;
      cs_rise   = 1'b0;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      off_now   = '0;
      state_next = state_reg;
      state_next.cs_n_d = cs_n_s;
      state_next.sclk_d = sclk_s;
      cs_fall   = state_reg.cs_n_d & ~cs_n_s;
      cs_rise   = ~state_reg.cs_n_d & cs_n_s;
      sclk_rise = ~state_reg.sclk_d & sclk_s;
      sclk_fall = state_reg.sclk_d & ~sclk_s;

      // over-temperature knocks out the gate of each hot output; it stays out until rewritten
      state_next.gate_off = state_reg.gate_off | flags_s.over_temp;
      // over-voltage knocks out all gates and marks the report
      if (flags_s.over_volt) begin
         state_next.gate_off = `ALL_OFF;
         state_next.ov_seen  = 1'b1;
      end
      off_now = state_reg.command | state_reg.gate_off;

      if (state_reg.filter_cnt != '0) begin
         state_next.filter_cnt = state_reg.filter_cnt - `FILTER_CNT_W'(1);
      end

      case (state_reg.link)
         LINK_IDLE: begin
            state_next.so_oe_n = 1'b1;
            if (cs_fall) begin
               state_next.link    = LINK_FRAME;
               state_next.so_oe_n = 1'b0;
               if (state_reg.ov_seen) begin
                  state_next.shift = `ALL_OFF;
               end else begin
                  state_next.shift = drain_status(off_now, state_reg.command,
                                                  flags_s.drain_below,
                                                  state_reg.filter_cnt == '0);
               end
               state_next.so = state_next.shift[`WORD_W-1];
            end
         end
         LINK_FRAME: begin
            if (sclk_fall) begin
               state_next.shift = {state_reg.shift[`WORD_W-2:0], si_s};
            end
            if (sclk_rise) begin
               state_next.so = state_reg.shift[`WORD_W-1];
            end
            if (cs_rise) begin
               state_next.link     = LINK_IDLE;
               state_next.so_oe_n  = 1'b1;
               state_next.command  = state_reg.shift;
               state_next.gate_off = flags_s.over_volt ? `ALL_OFF : flags_s.over_temp;
               state_next.ov_seen  = flags_s.over_volt;
               state_next.filter_cnt = FILTER_LOAD;
            end
         end
         default: begin
            state_next.link = LINK_IDLE;
         end
      endcase
      state_next.switch_off = state_next.command | state_next.gate_off;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg            <= '0;
         state_reg.link       <= LINK_IDLE;
         state_reg.cs_n_d     <= 1'b1;
         state_reg.command    <= `ALL_OFF;
         state_reg.so_oe_n    <= 1'b1;
         state_reg.switch_off <= `ALL_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   assign so         = state_reg.so;
   assign so_oe_n    = state_reg.so_oe_n;
   assign switch_off = state_reg.switch_off;
endmodule : octal_switch_spi
`default_nettype wire

// ---- hw/octal_switch_regs.svh ----
// timing counts and fixed values for the octal switch serial logic
`ifndef OCTAL_SWITCH_REGS_SVH
`define OCTAL_SWITCH_REGS_SVH
`define CLK_PERIOD_NS        20
`define OPEN_FILTER_MIN_NS   25000
`define OPEN_FILTER_CYCLES   ((`OPEN_FILTER_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILTER_CNT_W         11
`define WORD_W               8
`define ALL_OFF              8'hFF
`define BIT_CNT_W            3
`endif

// ---- hw/octal_switch_pkg.sv ----
// types shared by the octal switch serial logic
package octal_switch_pkg;
   typedef logic [7:0] word_t;
   typedef enum logic [1:0] {
      LINK_IDLE  = 2'b00,
      LINK_FRAME = 2'b01
   } link_state_t;
   typedef struct packed {
      word_t over_temp;
      logic  over_volt;
      word_t drain_below;
   } fault_flags_t;
endpackage : octal_switch_pkg

// ---- hw/sync2.sv ----
// two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] async_in,
   input  wire logic [W-1:0] reset_val,
   output var  logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] first;
      logic [W-1:0] second;
   } sync_state_t;
   sync_state_t state_reg;
   sync_state_t state_next;

   always_comb begin
      state_next.first  = async_in;
      state_next.second = state_reg.first;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         // both flops start at the idle level, so no false edge follows reset
         state_reg <= {reset_val, reset_val};
      end else begin
         state_reg <= state_next;
      end
   end

   // reset_val lets the caller pick the idle level seen during reset
   assign sync_out = reset ? reset_val : state_reg.second;
endmodule : sync2
`default_nettype wire

// ---- tb/octal_switch_spi_sva.sv ----
// port assertions for the octal switch serial logic
`timescale 1ns/1ns
`default_nettype none
module octal_switch_spi_sva
   import octal_switch_pkg::*;
(
   input wire logic  clk,
   input wire logic  reset,
   input wire logic  cs_n,
   input wire logic  sclk,
   input wire word_t over_temp,
   input wire logic  over_volt,
   input wire logic  so,
   input wire logic  so_oe_n,
   input wire word_t switch_off
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // five samples cover the two sync flops and the edge register
   sequence s_idle; cs_n[*5]; endsequence
   sequence s_sel; !cs_n[*5]; endsequence
   property p_rst; $fell(reset) |-> switch_off == 8'hFF && so_oe_n; endproperty
   a_rst: assert property (p_rst) else $error("reset left outputs on");
   property p_idle; s_idle |-> so_oe_n; endproperty
   a_idle: assert property (p_idle) else $error("so driven while deselected");
   property p_sel; s_sel |-> !so_oe_n; endproperty
   a_sel: assert property (p_sel) else $error("so not driven while selected");
   property p_so; !so_oe_n && !$past(so_oe_n) && $changed(so) |-> $past(sclk, 2) && !$past(sclk, 5);
   endproperty
   a_so: assert property (p_so) else $error("so moved without sclk rise");
   property p_hold; (!cs_n && !over_volt && over_temp == 8'h00)[*6] |-> $stable(switch_off);
   endproperty
   a_hold: assert property (p_hold) else $error("switches moved inside frame");
   property p_cause; $changed(switch_off) |-> $past(cs_n, 2) || over_volt || over_temp != 8'h00;
   endproperty
   a_cause: assert property (p_cause) else $error("switches moved without cause");
   property p_ov; over_volt[*5] |-> switch_off == 8'hFF; endproperty
   a_ov: assert property (p_ov) else $error("output on during over-voltage");
   property p_ot; $stable(over_temp)[*5] |-> (switch_off & over_temp) == over_temp; endproperty
   a_ot: assert property (p_ot) else $error("hot output still on");
endmodule : octal_switch_spi_sva
bind octal_switch_spi octal_switch_spi_sva u_sva (.clk, .reset, .cs_n, .sclk, .over_temp,
   .over_volt, .so, .so_oe_n, .switch_off);
`default_nettype wire

// ---- tb/spi_host.sv ----
// serial master model for the octal switch link
`timescale 1ns/1ns
`default_nettype none
module spi_host
   import octal_switch_pkg::*;
(
   input  wire logic clk,
   input  wire logic so,
   output var  logic cs_n,
   output var  logic sclk,
   output var  logic si
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si   = 1'b0;
   end
   // sclk rests low at both select edges; half period is four clocks (80 ns)
   task automatic xfer(input word_t cmd, output word_t st);
      cs_n <= 1'b0;
      repeat (4) @(posedge clk);
      // si moves in the middle of the low phase, away from the sampling fall
      for (int i = 7; i >= 0; i--) begin
         si <= cmd[i];
         repeat (2) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         // the bit presented after this rise is read before the fall
         st[i] = so;
         sclk <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      cs_n <= 1'b1;
      si   <= ~cmd[0];
      repeat (4) @(posedge clk);
   endtask : xfer
endmodule : spi_host
`default_nettype wire

// ---- tb/tb_octal_switch_spi.sv ----
// self-checking bench for the octal switch serial logic
`timescale 1ns/1ns
`default_nettype none
module tb_octal_switch_spi;
   import octal_switch_pkg::*;
   logic      clk;
   logic      reset;
   logic      cs_n;
   logic      sclk;
   logic      si;
   logic      so;
   logic      so_oe_n;
   logic      over_volt;
   word_t     over_temp;
   word_t     drain_below;
   word_t     switch_off;
   word_t     st;
   int        fails;
   int        num_checks;
   wire logic so_line = so_oe_n ? 1'bz : so;
   octal_switch_spi u_octal_switch_spi (.clk, .reset, .cs_n, .sclk, .si, .over_temp,
      .over_volt, .drain_below, .so, .so_oe_n, .switch_off);
   spi_host u_spi_host (.clk, .so(so_line), .cs_n, .sclk, .si);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input string name, input word_t seen, input word_t exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // wr checks the status read during each write against exp; gap 5100 keeps spacing above 100 us
   task automatic wr(input word_t cmd, input word_t exp, input int gap);
      repeat (gap) @(posedge clk);
      u_spi_host.xfer(cmd, st);
      check("status", st, exp);
   endtask : wr
   task automatic t_start;
      check("switch_off", switch_off, 8'hFF);
      check("so_oe_n", {7'h00, so_oe_n}, 8'h01);
      wr(8'hA5, 8'hFF, 0);
      wr(8'hA5, 8'hA5, 0);
      check("switch_off", switch_off, 8'hA5);
   endtask : t_start
   task automatic t_temp;
      over_temp <= 8'h02;
      repeat (8) @(posedge clk);
      check("switch_off", switch_off, 8'hA7);
      over_temp <= 8'h00;
      repeat (8) @(posedge clk);
      check("switch_off", switch_off, 8'hA7);
      wr(8'hA5, 8'hA7, 5100);
      check("switch_off", switch_off, 8'hA5);
   endtask : t_temp
   task automatic t_volt;
      over_volt <= 1'b1;
      repeat (8) @(posedge clk);
      over_volt <= 1'b0;
      repeat (8) @(posedge clk);
      check("switch_off", switch_off, 8'hFF);
      wr(8'hA5, 8'hFF, 5100);
      check("switch_off", switch_off, 8'hA5);
   endtask : t_volt
   task automatic t_open;
      drain_below <= 8'h03;
      wr(8'hA5, 8'hA4, 5100);
      wr(8'hA5, 8'hA5, 0);
      drain_below <= 8'h00;
      wr(8'hA5, 8'hA5, 5100);
   endtask : t_open
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   initial begin
      fails       = 0;
      num_checks  = 0;
      reset       = 1'b1;
      over_volt   = 1'b0;
      over_temp   = 8'h00;
      drain_below = 8'h00;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      t_start;
      t_temp;
      t_volt;
      t_open;
      end_of_test;
   end
endmodule : tb_octal_switch_spi
`default_nettype wire
